// ==== cbt_pkg.sv ====
`default_nettype none
package cbt_pkg;
   // Register offsets
   localparam logic [7:0] CBT_OFS_TEC = 8'h1c;
   localparam logic [7:0] CBT_OFS_REC = 8'h1d;
   localparam logic [7:0] CBT_OFS_TIMING_C = 8'h28;
   localparam logic [7:0] CBT_OFS_TIMING_B = 8'h29;
   localparam logic [7:0] CBT_OFS_TIMING_A = 8'h2a;
   localparam logic [7:0] CBT_RST_TIMING = 8'h00;
   // Writable bits of timing_reg_c, the rest read as zero
   localparam logic [7:0] CBT_C_WMASK = 8'h47;
   // Field positions
   localparam int CBT_A_JW_HI = 7;
   localparam int CBT_A_JW_LO = 6;
   localparam int CBT_A_PRESC_HI = 5;
   localparam int CBT_B_PH2SRC = 7;
   localparam int CBT_B_TRIPLE = 6;
   localparam int CBT_B_PH1_HI = 5;
   localparam int CBT_B_PH1_LO = 3;
   localparam int CBT_B_PROP_HI = 2;
   localparam int CBT_C_WAKE = 6;
   localparam int CBT_C_PH2_HI = 2;
   // Timing and protocol counts
   localparam logic [3:0] CBT_IPT_TQ = 4'h2;
   localparam logic [2:0] CBT_STUFF_RUN = 3'h5;
   localparam logic [14:0] CBT_CRC_POLY = 15'h4599;
   localparam logic [8:0] CBT_TEC_STEP = 9'h008;
   localparam logic [8:0] CBT_TEC_BUSOFF = 9'h100;
   localparam logic [8:0] CBT_TEC_PASSIVE = 9'h080;
   localparam logic [8:0] CBT_TEC_WARN = 9'h060;
   localparam logic [7:0] CBT_REC_PASSIVE = 8'h80;
   localparam logic [7:0] CBT_REC_WARN = 8'h60;
   localparam logic [7:0] CBT_REC_CAP = 8'h7f;
   localparam logic [3:0] CBT_RECOV_BITS = 4'hb;
   localparam logic [6:0] CBT_RECOV_LAST = 7'h7f;
   localparam logic [3:0] CBT_EF_FLAG_BITS = 4'h6;
   localparam logic [3:0] CBT_EF_LAST = 4'hd;

   typedef enum logic [3:0] {
      SEG_SYNC = 4'b0001,
      SEG_PROP = 4'b0010,
      SEG_PH1 = 4'b0100,
      SEG_PH2 = 4'b1000
   } cbt_seg_t;

   typedef enum logic [2:0] {
      EST_ACTIVE = 3'b001,
      EST_PASSIVE = 3'b010,
      EST_BUSOFF = 3'b100
   } cbt_est_t;

   typedef enum logic [3:0] {
      FLD_IDLE = 4'h0, FLD_SOF = 4'h1, FLD_ARB = 4'h2, FLD_CTRL = 4'h3,
      FLD_DATA = 4'h4, FLD_CRC = 4'h5, FLD_CRC_DELIM = 4'h6,
      FLD_ACK_SLOT = 4'h7, FLD_ACK_DELIM = 4'h8, FLD_EOF = 4'h9,
      FLD_IFS = 4'ha
   } cbt_fld_t;

   typedef struct packed {
      cbt_fld_t fld;
      logic tx_active;
      logic tx_bit;
   } cbt_frame_ctx_t;

   typedef struct packed {
      logic [2:0] rx_sync;
      logic rx_filt;
      logic [7:0] timing_reg_a;
      logic [7:0] timing_reg_b;
      logic [7:0] timing_reg_c;
      logic [6:0] presc_cnt;
      cbt_seg_t seg;
      logic [3:0] seg_cnt;
      logic [3:0] ph1_ext;
      logic [3:0] ph2_cut;
      logic [4:0] bit_tq;
      logic synced;
      logic prev_smp;
      logic [1:0] half_smp;
      logic rx_bit;
      logic rx_valid;
      logic bit_start;
      logic tx_pin;
      logic [2:0] run_cnt;
      logic run_val;
      logic [14:0] crc_calc;
      logic [14:0] crc_recv;
      logic [8:0] transmit_error_count;
      logic [7:0] receive_error_count;
      cbt_est_t est;
      logic [3:0] idle_bits;
      logic [6:0] idle_seqs;
      logic [3:0] ef_cnt;
      logic ef_act;
      logic ef_pend;
      logic retx;
      logic [4:0] err_kind;
      logic warn;
      logic [7:0] rdata;
   } cbt_state_t;
endpackage
`default_nettype wire

// ==== cbt_core.sv ====
// How it works
// RULE1 - Timing registers take writes only while configuration mode is on.
// RULE2 - One quantum lasts two times prescaler plus one clock cycles.
// RULE3 - Jump width codes 0 to 3 give one to four quanta.
// RULE4 - Propagation segment lasts its field plus one quanta.
// RULE5 - Phase one lasts its field plus one quanta; its end samples.
// RULE6 - Triple sampling takes majority of three samples half a quantum apart.
// RULE7 - Without triple sampling the line is read once at phase one end.
// RULE8 - Phase two comes from register c, or max of phase one and two.
// RULE9 - Phase two field plus one quanta; host keeps it at two or more.
// RULE10 - Register c bit six enables the wake-up filter.
// RULE11 - Receiver checks the CRC over start through data, error on mismatch.
// RULE12 - Transmitter seeing recessive acknowledge slot flags acknowledge error.
// RULE13 - Dominant level in delimiters, end of frame or interframe is form error.
// RULE14 - Sent bit differing from bus is bit error, except a recessive bit sent in arbitration or ack slot.
// RULE15 - Six equal bits from start of frame through CRC is stuff error.
// RULE16 - Any error short of bus-off entry aborts, sends an error frame and, when transmitting, asks for a retry.
// RULE17 - Active nodes flag with dominant bits, passive nodes with recessive.
// RULE18 - Bus-off node neither transmits nor receives.
// RULE19 - Passive when either counter reaches 128, else active.
// RULE20 - Transmit counter reaching 256 means bus-off.
// RULE21 - Bus-off ends alone after 128 runs of 11 recessive bits.
// RULE22 - Counters move by the usual CAN steps and are readable.
// RULE23 - Warning flag follows either counter at or above 96.
// RULE24 - Each bit opens with a one-quantum synchronization segment.
// RULE25 - Large phase errors stretch phase one or trim phase two by jump width.
// RULE26 - Bit time is sync plus propagation plus both phase segments.
`timescale 1ns/10ps
`default_nettype none
module cbt_core
   import cbt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic bus_receive_pin_i,
   input wire cbt_frame_ctx_t ctx_i,
   input wire logic config_mode_i,
   input wire logic tx_ok_i,
   input wire logic rx_ok_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic bus_transmit_o,
   output logic rx_bit_o,
   output logic rx_valid_o,
   output logic bit_start_o,
   output logic [4:0] err_kind_o,
   output logic err_frame_o,
   output logic retransmit_o,
   output logic error_warning_flag_o,
   output logic err_passive_o,
   output logic bus_off_o,
   output logic wakeup_filter_enable_o
);

   cbt_state_t state_ff;
   cbt_state_t nxt_state;

   logic [7:0] ta;
   logic [7:0] tb;
   logic [7:0] tc;
   logic [3:0] jump_width;
   logic [3:0] propagation_length;
   logic [3:0] ph1_base;
   logic [3:0] phase_one_length;
   logic [3:0] ph2_base;
   logic [3:0] phase_two_length;
   logic [3:0] seg_len;
   logic tq_tick;
   logic half_tick;
   logic seg_end;
   logic smp_evt;
   logic new_filt;
   logic smp_val;

   assign ta = state_ff.timing_reg_a;
   assign tb = state_ff.timing_reg_b;
   assign tc = state_ff.timing_reg_c;
   assign jump_width = {2'b00, ta[CBT_A_JW_HI:CBT_A_JW_LO]} + 4'h1; // RULE3
   assign propagation_length = {1'b0, tb[CBT_B_PROP_HI:0]} + 4'h1; // RULE4
   assign ph1_base = {1'b0, tb[CBT_B_PH1_HI:CBT_B_PH1_LO]} + 4'h1; // RULE5
   assign phase_one_length = ph1_base + state_ff.ph1_ext; // RULE25

   always_comb begin
      if (tb[CBT_B_PH2SRC]) begin
         ph2_base = {1'b0, tc[CBT_C_PH2_HI:0]} + 4'h1; // RULE9
      end else if (ph1_base > CBT_IPT_TQ) begin
         ph2_base = ph1_base; // RULE8
      end else begin
         ph2_base = CBT_IPT_TQ; // RULE8
      end
   end

   assign phase_two_length = ph2_base - state_ff.ph2_cut; // RULE25

   always_comb begin
      case (state_ff.seg) // RULE26
         SEG_SYNC: seg_len = 4'h1; // RULE24
         SEG_PROP: seg_len = propagation_length;
         SEG_PH1: seg_len = phase_one_length;
         SEG_PH2: seg_len = phase_two_length;
         default: seg_len = 4'h1;
      endcase
   end

   // Quantum is 2*(prescaler+1) clocks; half quantum falls mid-count
   assign tq_tick = state_ff.presc_cnt == {ta[CBT_A_PRESC_HI:0], 1'b1}; // RULE2
   assign half_tick = tq_tick ||
      (state_ff.presc_cnt == {1'b0, ta[CBT_A_PRESC_HI:0]}); // RULE6
   assign seg_end = tq_tick && ((state_ff.seg_cnt + 4'h1) == seg_len);
   assign smp_evt = seg_end && (state_ff.seg == SEG_PH1); // RULE5

   // Level changes only once stages two and three agree
   assign new_filt = (state_ff.rx_sync[1] == state_ff.rx_sync[2]) ?
      state_ff.rx_sync[2] : state_ff.rx_filt;

   always_comb begin
      if (tb[CBT_B_TRIPLE]) begin
         smp_val = (state_ff.half_smp[1] & state_ff.half_smp[0]) |
            (state_ff.half_smp[1] & state_ff.rx_filt) |
            (state_ff.half_smp[0] & state_ff.rx_filt); // RULE6
      end else begin
         smp_val = state_ff.rx_filt; // RULE7
      end
   end

   function automatic logic [14:0] crc_step(input logic [14:0] c,
                                            input logic b);
      crc_step = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? CBT_CRC_POLY : 15'h0000);
   endfunction

   always_comb begin
      logic fall;
      logic restart;
      logic stuff_bit;
      logic checks_on;
      logic [4:0] kind;
      logic [3:0] rem;
      logic [8:0] t9;
      logic [7:0] r8;
      fall = 1'b0;
      restart = 1'b0;
      stuff_bit = 1'b0;
      checks_on = 1'b0;
      kind = 5'h00;
      rem = 4'h0;
      t9 = state_ff.transmit_error_count;
      r8 = state_ff.receive_error_count;
      nxt_state = state_ff;
      nxt_state.rx_sync = {state_ff.rx_sync[1:0], bus_receive_pin_i};
      nxt_state.rx_filt = new_filt;
      nxt_state.rx_valid = 1'b0;
      nxt_state.bit_start = 1'b0;
      nxt_state.retx = 1'b0;
      nxt_state.err_kind = 5'h00;

      // Quantum and segment sequencing
      nxt_state.presc_cnt = tq_tick ? 7'h00 : state_ff.presc_cnt + 7'h01;
      if (half_tick) begin
         nxt_state.half_smp = {state_ff.half_smp[0], state_ff.rx_filt};
      end
      if (tq_tick) begin
         if (state_ff.bit_tq != 5'h1f) begin
            nxt_state.bit_tq = state_ff.bit_tq + 5'h01;
         end
         nxt_state.seg_cnt = state_ff.seg_cnt + 4'h1;
         if (seg_end) begin
            nxt_state.seg_cnt = 4'h0;
            case (state_ff.seg) // RULE26
               SEG_SYNC: nxt_state.seg = SEG_PROP;
               SEG_PROP: nxt_state.seg = SEG_PH1;
               SEG_PH1: nxt_state.seg = SEG_PH2;
               default: begin
                  nxt_state.seg = SEG_SYNC; // RULE24
                  nxt_state.bit_tq = 5'h00;
                  nxt_state.ph1_ext = 4'h0;
                  nxt_state.ph2_cut = 4'h0;
                  nxt_state.synced = 1'b0;
                  nxt_state.bit_start = 1'b1;
               end
            endcase
         end
      end

      // One sync per bit, only after a recessive sample
      fall = state_ff.rx_filt & ~new_filt;
      if (fall && !state_ff.synced && state_ff.prev_smp) begin
         nxt_state.synced = 1'b1;
         rem = phase_two_length - state_ff.seg_cnt;
         if (ctx_i.fld == FLD_IDLE) begin
            restart = 1'b1;
         end else if (state_ff.seg == SEG_PH2) begin
            if (rem <= jump_width) begin
               restart = 1'b1; // RULE25
            end else begin
               nxt_state.ph2_cut = jump_width; // RULE25
            end
         end else if (state_ff.seg != SEG_SYNC &&
                      !(ctx_i.tx_active && !ctx_i.tx_bit)) begin
            if (state_ff.bit_tq <= {1'b0, jump_width}) begin
               restart = 1'b1; // RULE25
            end else begin
               nxt_state.ph1_ext = jump_width; // RULE25
            end
         end
      end
      if (restart) begin
         // Edge becomes the sync segment of a fresh bit
         nxt_state.seg = SEG_SYNC; // RULE24
         nxt_state.seg_cnt = 4'h0;
         nxt_state.presc_cnt = 7'h00;
         nxt_state.bit_tq = 5'h00;
         nxt_state.ph1_ext = 4'h0;
         nxt_state.ph2_cut = 4'h0;
         nxt_state.bit_start = 1'b1;
      end

      // Sample point work
      checks_on = smp_evt && (state_ff.est != EST_BUSOFF) &&
         !state_ff.ef_act && !state_ff.ef_pend;
      if (smp_evt) begin
         nxt_state.prev_smp = smp_val;
         nxt_state.rx_bit = smp_val;
      end
      if (checks_on && ctx_i.fld >= FLD_SOF && ctx_i.fld <= FLD_CRC) begin
         stuff_bit = (state_ff.run_cnt == CBT_STUFF_RUN) &&
            (smp_val != state_ff.run_val);
         if (ctx_i.fld == FLD_SOF) begin
            nxt_state.run_cnt = 3'h1;
            nxt_state.run_val = smp_val;
            nxt_state.crc_calc = crc_step(15'h0000, smp_val); // RULE11
            nxt_state.crc_recv = 15'h0000;
         end else begin
            if (smp_val == state_ff.run_val) begin
               nxt_state.run_cnt = state_ff.run_cnt + 3'h1;
               kind[3] = state_ff.run_cnt == CBT_STUFF_RUN; // RULE15
            end else begin
               nxt_state.run_cnt = 3'h1;
               nxt_state.run_val = smp_val;
            end
            if (!stuff_bit && ctx_i.fld != FLD_CRC) begin
               nxt_state.crc_calc = crc_step(state_ff.crc_calc,
                                             smp_val); // RULE11
            end else if (!stuff_bit) begin
               nxt_state.crc_recv = {state_ff.crc_recv[13:0], smp_val};
            end
         end
      end
      if (checks_on) begin
         kind[0] = ctx_i.fld == FLD_CRC_DELIM && !ctx_i.tx_active &&
            state_ff.crc_recv != state_ff.crc_calc; // RULE11
         kind[1] = ctx_i.tx_active && ctx_i.fld == FLD_ACK_SLOT &&
            smp_val; // RULE12
         kind[2] = !smp_val && (ctx_i.fld == FLD_CRC_DELIM ||
            ctx_i.fld == FLD_ACK_DELIM || ctx_i.fld == FLD_EOF ||
            ctx_i.fld == FLD_IFS); // RULE13
         kind[4] = ctx_i.tx_active && (smp_val != ctx_i.tx_bit) &&
            !(ctx_i.tx_bit && (ctx_i.fld == FLD_ARB ||
            ctx_i.fld == FLD_ACK_SLOT)); // RULE14
      end
      if (|kind) begin
         nxt_state.err_kind = kind;
         nxt_state.ef_pend = 1'b1; // RULE16
         nxt_state.retx = ctx_i.tx_active; // RULE16
         if (ctx_i.tx_active) begin
            t9 = (t9 >= CBT_TEC_BUSOFF - CBT_TEC_STEP) ?
               CBT_TEC_BUSOFF : t9 + CBT_TEC_STEP; // RULE22
         end else if (r8 != 8'hff) begin
            r8 = r8 + 8'h01; // RULE22
         end
      end
      if (state_ff.est != EST_BUSOFF) begin
         if (tx_ok_i && t9 != 9'h000) begin
            t9 = t9 - 9'h001; // RULE22
         end
         if (rx_ok_i && r8 > CBT_REC_CAP) begin
            r8 = CBT_REC_CAP; // RULE22
         end else if (rx_ok_i && r8 != 8'h00) begin
            r8 = r8 - 8'h01; // RULE22
         end
      end

      // Error state
      if (state_ff.est == EST_BUSOFF) begin
         if (smp_evt && smp_val) begin
            nxt_state.idle_bits = state_ff.idle_bits + 4'h1;
            if (state_ff.idle_bits + 4'h1 == CBT_RECOV_BITS) begin
               nxt_state.idle_bits = 4'h0;
               nxt_state.idle_seqs = state_ff.idle_seqs + 7'h01;
               if (state_ff.idle_seqs == CBT_RECOV_LAST) begin
                  nxt_state.est = EST_ACTIVE; // RULE21
                  t9 = 9'h000;
                  r8 = 8'h00;
               end
            end
         end else if (smp_evt) begin
            nxt_state.idle_bits = 4'h0;
         end
      end else if (t9 >= CBT_TEC_BUSOFF) begin
         nxt_state.est = EST_BUSOFF; // RULE20
         nxt_state.idle_bits = 4'h0;
         nxt_state.idle_seqs = 7'h00;
         nxt_state.ef_act = 1'b0;
         nxt_state.ef_pend = 1'b0;
      end else if (t9 >= CBT_TEC_PASSIVE || r8 >= CBT_REC_PASSIVE) begin
         nxt_state.est = EST_PASSIVE; // RULE19
      end else begin
         nxt_state.est = EST_ACTIVE; // RULE19
      end
      nxt_state.transmit_error_count = t9;
      nxt_state.receive_error_count = r8;
      nxt_state.warn = (t9 >= CBT_TEC_WARN) || (r8 >= CBT_REC_WARN); // RULE23
      nxt_state.rx_valid = smp_evt && nxt_state.est != EST_BUSOFF; // RULE18

      // Error frame: six flag bits then eight recessive delimiter bits
      if (nxt_state.bit_start && nxt_state.est != EST_BUSOFF) begin
         if (state_ff.ef_act) begin
            nxt_state.ef_act = state_ff.ef_cnt != CBT_EF_LAST;
            nxt_state.ef_cnt = state_ff.ef_cnt + 4'h1;
         end else if (nxt_state.ef_pend) begin
            nxt_state.ef_act = 1'b1; // RULE16
            nxt_state.ef_pend = 1'b0;
            nxt_state.ef_cnt = 4'h0;
         end
      end
      if (nxt_state.est == EST_BUSOFF) begin
         nxt_state.tx_pin = 1'b1; // RULE18
      end else if (nxt_state.bit_start) begin
         if (nxt_state.ef_act) begin
            // Passive flags stay recessive so they cannot disturb others
            nxt_state.tx_pin = (nxt_state.ef_cnt >= CBT_EF_FLAG_BITS) ||
               nxt_state.est == EST_PASSIVE; // RULE17
         end else begin
            nxt_state.tx_pin = !ctx_i.tx_active || ctx_i.tx_bit;
         end
      end

      // Register access
      if (reg_wr_i && config_mode_i) begin
         if (reg_addr_i == CBT_OFS_TIMING_A) begin
            nxt_state.timing_reg_a = reg_wdata_i; // RULE1
         end else if (reg_addr_i == CBT_OFS_TIMING_B) begin
            nxt_state.timing_reg_b = reg_wdata_i; // RULE1
         end else if (reg_addr_i == CBT_OFS_TIMING_C) begin
            nxt_state.timing_reg_c = reg_wdata_i & CBT_C_WMASK; // RULE1
         end
      end
      if (reg_rd_i) begin
         if (reg_addr_i == CBT_OFS_TEC) begin
            nxt_state.rdata = state_ff.transmit_error_count[8] ? 8'hff : state_ff.transmit_error_count[7:0];
         end else if (reg_addr_i == CBT_OFS_REC) begin
            nxt_state.rdata = state_ff.receive_error_count; // RULE22
         end else if (reg_addr_i == CBT_OFS_TIMING_A) begin
            nxt_state.rdata = ta;
         end else if (reg_addr_i == CBT_OFS_TIMING_B) begin
            nxt_state.rdata = tb;
         end else if (reg_addr_i == CBT_OFS_TIMING_C) begin
            nxt_state.rdata = tc;
         end else begin
            nxt_state.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= '0;
         state_ff.rx_sync <= 3'h7;
         state_ff.rx_filt <= 1'b1;
         state_ff.timing_reg_a <= CBT_RST_TIMING;
         state_ff.timing_reg_b <= CBT_RST_TIMING;
         state_ff.timing_reg_c <= CBT_RST_TIMING;
         state_ff.seg <= SEG_SYNC;
         state_ff.prev_smp <= 1'b1;
         state_ff.tx_pin <= 1'b1;
         state_ff.est <= EST_ACTIVE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata_o = state_ff.rdata;
   assign bus_transmit_o = state_ff.tx_pin;
   assign rx_bit_o = state_ff.rx_bit;
   assign rx_valid_o = state_ff.rx_valid;
   assign bit_start_o = state_ff.bit_start;
   assign err_kind_o = state_ff.err_kind;
   assign err_frame_o = state_ff.ef_act;
   assign retransmit_o = state_ff.retx;
   assign error_warning_flag_o = state_ff.warn;
   assign err_passive_o = state_ff.est[1];
   assign bus_off_o = state_ff.est[2];
   assign wakeup_filter_enable_o = tc[CBT_C_WAKE]; // RULE10

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_cfg_write_lock: assert property ( // RULE1
      reg_wr_i && !config_mode_i |=> $stable(ta) && $stable(tb) && $stable(tc))
      else $error("timing register changed outside configuration mode");
   a_quantum_len: assert property ( // RULE2
      !tq_tick |=> state_ff.presc_cnt == $past(state_ff.presc_cnt) + 7'h01 ||
      bit_start_o)
      else $error("prescaler count skipped outside a quantum tick");
   // A hard sync on the sample edge may restart the bit instead
   a_sample_phase1: assert property ( // RULE5
      smp_evt |=> state_ff.seg == SEG_PH2 || bit_start_o)
      else $error("sample not at end of phase one");
   a_single_sample: assert property ( // RULE7
      smp_evt && !tb[CBT_B_TRIPLE] |=> rx_bit_o == $past(state_ff.rx_filt))
      else $error("single sample value wrong");
   a_warn_level: assert property ( // RULE23
      error_warning_flag_o == (state_ff.transmit_error_count >= CBT_TEC_WARN ||
      state_ff.receive_error_count >= CBT_REC_WARN))
      else $error("warning flag does not follow counters");
   a_passive_level: assert property ( // RULE19
      err_passive_o |-> state_ff.transmit_error_count >= CBT_TEC_PASSIVE ||
      state_ff.receive_error_count >= CBT_REC_PASSIVE)
      else $error("passive without a counter at limit");
   a_busoff_entry: assert property ( // RULE20
      state_ff.transmit_error_count[8] && !$past(bus_off_o) |-> bus_off_o)
      else $error("transmit counter at limit but not bus-off");
   a_busoff_quiet: assert property ( // RULE18
      bus_off_o |-> bus_transmit_o && !rx_valid_o)
      else $error("bus-off node drives or receives");
   // Bus-off entry drops the pending frame on purpose
   a_error_flags: assert property ( // RULE16
      (|err_kind_o) && !bus_off_o |-> state_ff.ef_pend || err_frame_o)
      else $error("error not followed by error frame");
   a_flag_start: assert property ( // RULE16
      $fell(state_ff.ef_pend) && !bus_off_o |-> err_frame_o && bit_start_o)
      else $error("pending error frame did not start at bit start");
   a_active_flag: assert property ( // RULE17
      $rose(err_frame_o) && !err_passive_o |-> !bus_transmit_o)
      else $error("active error flag not dominant");

   c_stuff_error: cover property (err_kind_o[3]);
   c_ack_error: cover property (err_kind_o[1] && retransmit_o);
   c_go_passive: cover property ($rose(err_passive_o));
   c_recover: cover property ($fell(bus_off_o));

endmodule // cbt_core
`default_nettype wire

// ==== cbt_node_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cbt_node_model (
   input wire logic sys_clk_i,
   input wire logic dut_tx_i,
   input wire logic dom_i,
   output logic bus_o
);
   logic dom_ff = 1'b0;
   // Other node changes its drive only just after a clock edge
   always_ff @(posedge sys_clk_i) begin
      dom_ff <= dom_i;
   end
   // Wired-AND line: dominant from either node wins
   assign bus_o = dut_tx_i & ~dom_ff;
endmodule // cbt_node_model
`default_nettype wire

// ==== cbt_core_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module cbt_core_tb_top;
   import cbt_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic dom = 1'b0, cfg = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
   logic txok = 1'b0, rxok = 1'b0;
   logic [7:0] adr = 8'h00, wd = 8'h00, rdat;
   cbt_frame_ctx_t ctx = '{FLD_IDLE, 1'b0, 1'b1};
   logic bus, tx, rxb, rxv, bst, efr, retx, warn, pas, boff, wake;
   logic [4:0] ek;
   logic [31:0] seed = 32'h0671_8ffd;
   logic [7:0] b, c, qr[$];
   logic [5:0] qe[$];
   int n_mismatch = 0, total_checks = 0, k, p, per, ex, i;
   cbt_node_model nm_u (.sys_clk_i(sys_clk_i), .dut_tx_i(tx), .dom_i(dom),
      .bus_o(bus));
   cbt_core dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .bus_receive_pin_i(bus), .ctx_i(ctx), .config_mode_i(cfg),
      .tx_ok_i(txok), .rx_ok_i(rxok), .reg_addr_i(adr), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .bus_transmit_o(tx), .rx_bit_o(rxb), .rx_valid_o(rxv),
      .bit_start_o(bst), .err_kind_o(ek), .err_frame_o(efr),
      .retransmit_o(retx), .error_warning_flag_o(warn),
      .err_passive_o(pas), .bus_off_o(boff), .wakeup_filter_enable_o(wake));
   always #2.5 sys_clk_i = ~sys_clk_i;
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic hang;
      n_mismatch++;
      conclude();
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic rw(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr <= 1'b1;
      adr <= a;
      wd <= d;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rr(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      rd <= 1'b1;
      adr <= a;
      qr.push_back(e);
      @(posedge sys_clk_i);
      rd <= 1'b0;
   endtask
   // Scoreboard: results are taken in order of arrival
   always @(posedge sys_clk_i) begin
      rd_d <= rd;
      if (rd_d) chk({1'b0, rdat}, {1'b0, qr.pop_front()});
      // State is unknown until the first reset edge
      if (rst_n_i && ek !== 5'h00) begin
         chk({3'h0, retx, ek}, {3'h0, qe.pop_front()});
      end
   end
   task automatic period(input int e);
      int nv;
      nv = 0;
      for (k = 0; k < 500 && bst !== 1'b1; k++) @(negedge sys_clk_i);
      if (k == 500) hang();
      per = 0;
      do begin
         @(negedge sys_clk_i);
         per++;
         if (rxv === 1'b1) nv++;
      end while (bst !== 1'b1 && per < 500);
      chk(per[8:0], e[8:0]);
      chk(nv[8:0], 9'h001);
      chk({8'h00, rxb}, 9'h001);
      @(posedge sys_clk_i);
   endtask
   // Waits out the error pulse and the error frame that follows it
   task automatic w_idle(input logic etx);
      for (k = 0; k < 3000 && qe.size() != 0; k++) @(posedge sys_clk_i);
      if (k == 3000) hang();
      chk({8'h00, rxb}, {8'h00, ~dom});
      dom <= 1'b0;
      ctx <= '{FLD_IDLE, 1'b0, 1'b1};
      repeat (20) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk({8'h00, tx}, {8'h00, etx});
      for (k = 0; k < 3000 && efr !== 1'b0; k++) @(negedge sys_clk_i);
      if (k == 3000) hang();
      @(posedge sys_clk_i);
   endtask
   initial begin
      #450000;
      hang();
   end
   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      rr(CBT_OFS_TIMING_A, 8'h00);
      rr(CBT_OFS_TIMING_B, 8'h00);
      rr(CBT_OFS_TEC, 8'h00);
      rr(8'h00, 8'h00);
      rw(CBT_OFS_TIMING_C, 8'hff);
      rr(CBT_OFS_TIMING_C, 8'h47);
      @(negedge sys_clk_i);
      chk({8'h00, wake}, 9'h001);
      for (i = 0; i < 3; i++) begin
         seed = xs(seed);
         p = seed[1:0];
         b = seed[15:8];
         c = {1'b0, seed[22], 3'b000, seed[18:16] | 3'b001};
         rw(CBT_OFS_TIMING_A, {seed[7:6], 4'h0, seed[1:0]});
         rw(CBT_OFS_TIMING_B, b);
         rw(CBT_OFS_TIMING_C, c);
         ex = (b[5:3] > 3'd0) ? b[5:3] + 1 : 2;
         if (b[7]) ex = c[2:0] + 1;
         repeat (250) @(posedge sys_clk_i);
         period(2 * (p + 1) * (3 + b[2:0] + b[5:3] + ex));
      end
      rw(CBT_OFS_TIMING_A, 8'h00);
      rw(CBT_OFS_TIMING_B, 8'h00);
      rw(CBT_OFS_TIMING_C, 8'h00);
      cfg <= 1'b0;
      rw(CBT_OFS_TIMING_A, 8'h3f);
      rr(CBT_OFS_TIMING_A, 8'h00);
      period(10);
      ctx <= '{FLD_DATA, 1'b0, 1'b1};
      dom <= 1'b1;
      qe.push_back(6'h08);
      w_idle(1'b0);
      ctx <= '{FLD_EOF, 1'b0, 1'b1};
      dom <= 1'b1;
      qe.push_back(6'h04);
      w_idle(1'b0);
      rr(CBT_OFS_REC, 8'h02);
      rxok <= 1'b1;
      @(posedge sys_clk_i);
      rxok <= 1'b0;
      rr(CBT_OFS_REC, 8'h01);
      // Passive from the 16th error on, so that flag is already recessive
      for (i = 0; i < 32; i++) begin
         ctx <= '{FLD_ACK_SLOT, 1'b1, 1'b1};
         qe.push_back(6'h22);
         w_idle(i >= 15);
         p = 8 * (i + 1);
         if (i < 31) begin
            chk({6'h00, boff, pas, warn},
               {6'h00, 1'b0, p >= 128, p >= 96});
         end else begin
            chk({8'h00, boff}, 9'h001);
         end
      end
      rr(CBT_OFS_TEC, 8'hff);
      for (k = 0; k < 16000 && boff !== 1'b0; k++) @(negedge sys_clk_i);
      if (k == 16000) hang();
      chk({8'h00, boff}, 9'h000);
      rr(CBT_OFS_TEC, 8'h00);
      rr(CBT_OFS_REC, 8'h00);
      ctx <= '{FLD_DATA, 1'b1, 1'b1};
      dom <= 1'b1;
      qe.push_back(6'h30);
      w_idle(1'b0);
      txok <= 1'b1;
      @(posedge sys_clk_i);
      txok <= 1'b0;
      rr(CBT_OFS_TEC, 8'h07);
      repeat (4) @(posedge sys_clk_i);
      conclude();
   end
endmodule // cbt_core_tb_top
`default_nettype wire
